// File: verilog/vft_pkg.sv
// Package with register map, field layout, reset values and carrier types of the vertical frame timer.
package vft_pkg;

	// ==========================================================
	// Register word indices; the byte address is four times the index
	localparam int IDX_CTRL      = 0;
	localparam int IDX_LINE_TOT  = 1;
	localparam int IDX_HSYNC_E   = 2;
	localparam int IDX_HSERR     = 3;
	localparam int IDX_HBLANK_E  = 4;
	localparam int IDX_HBLANK_S  = 5;
	localparam int IDX_HAREA_S   = 6;
	localparam int IDX_HAREA_E   = 7;
	localparam int IDX_FRAME_TOT = 8;
	localparam int IDX_VSYNC_E   = 9;
	localparam int IDX_VBLANK_E  = 10;
	localparam int IDX_VBLANK_S  = 11;
	localparam int IDX_VAREA_S   = 12;
	localparam int IDX_VAREA_E   = 13;
	localparam int IDX_VINT      = 14;
	localparam int IDX_STATUS    = 15;
	localparam int IDX_LAST_TIM  = 14;
	localparam int ADDR_W        = 8;

	// ==========================================================
	// Control and status fields
	localparam int CTRL_W        = 4;
	localparam int CTRL_NOILACE_BIT = 0;
	localparam int CTRL_PINSEL_LSB  = 1;
	localparam int CTRL_EN_BIT   = 3;
	localparam logic [3:0] CTRL_RST = 4'h1;
	localparam int STAT_FIELD_BIT = 31;
	localparam int STAT_PIX_LSB   = 16;

	// ==========================================================
	// Output pin combinations and field identity
	typedef enum logic [1:0] {
		VFT_PINSEL_COMPOSITE = 2'h2,
		VFT_PINSEL_SEPARATE  = 2'h3
	} vft_pinsel_t;

	typedef enum logic {
		VFT_FIELD_ODD  = 1'b0,
		VFT_FIELD_EVEN = 1'b1
	} vft_field_t;

	// All sync and blank levels are active low; area is active high.
	typedef struct packed {
		logic hsync_n;
		logic vsync_n;
		logic composite_sync_out_n;
		logic cblank_n;
		logic hblank_n;
		logic vblank_n;
		logic area;
	} vft_sig_t;

	localparam vft_sig_t SIG_IDLE = 7'h7e;

	typedef struct packed {
		logic hsync_n;
		logic vsync_n;
		logic sync_or_hblank_n;
		logic blank_or_vblank_n;
		logic area;
	} vft_pins_t;

	localparam vft_pins_t PINS_IDLE = 5'h1e;

endpackage

// File: verilog/vft_frame_timer.sv
// Frame timer: pixel and line counters, sync, blank and area generation behind an APB register file.
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/10ps

// Operation
// - Noninterlaced line_counter starts at zero, steps at each pixel_counter wrap.
// - Vertical sync goes inactive at line end after count reaches (vert_sync_end-1)/2.
// - Serration stops where vertical sync ends; normal horizontal sync pulses follow.
// - At vert_blank_end vertical blank goes high; composite blank follows horizontal blank.
// - At vert_blank_start vertical blank and composite blank go low.
// - Area follows horizontal area from vert_area_start, forced low at vert_area_end.
// - At frame_total_lines: vertical sync low, counter to zero, serration region begins.
// - Any ordering of vertical compare values is accepted in noninterlaced mode.
// - Frame interrupt is signalled at frame_interrupt_line.
// - Interlace disable bit cleared selects interlaced mode.
// - Interlaced frames consist of odd and even fields.
// - Interlaced vertical retrace counts whole halflines.
// - Even field begins halfway across a line.
// - Line period is line_total_clocks plus one clocks.
// - Pin select 10 gives composite sync and blank; 11 gives separate blanks.
// - Interlace disable bit set selects noninterlaced mode, one field per frame.
// - pixel_counter counts from zero, wraps at line_total_clocks starting horizontal sync.
// - Pin transitions follow compare matches by two and a half clocks.
module vft_frame_timer #(
	parameter int CNT_W = 12
) (
	input  wire logic                         core_clk,
	input  wire logic                         resetn,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [vft_pkg::ADDR_W-1:0]   paddr,
	input  wire logic [31:0]                  pwdata,
	output logic      [31:0]                  prdata,
	output logic                              pready,
	output logic                              pslverr,
	output vft_pkg::vft_pins_t                video_pins,
	output vft_pkg::vft_sig_t                 all_signals,
	output logic                              frame_int_out,
	output logic                              field_out
);

	// ==========================================================
	// Register file
	logic [vft_pkg::CTRL_W-1:0] ctrl_ff;
	logic [CNT_W-1:0]           tim_ff [1:vft_pkg::IDX_LAST_TIM];
	logic [31:0]                prdata_ff;
	logic [5:0]                 idx;
	logic                       wr_go;
	logic                       bad_addr;
	logic [CNT_W-1:0]           pix_ff;
	logic [CNT_W-1:0]           line_ff;
	vft_pkg::vft_field_t        field_ff;

	assign idx      = paddr[7:2];
	assign bad_addr = (paddr[1:0] != 2'h0) || (pwrite && idx == 6'(vft_pkg::IDX_STATUS));
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && bad_addr;
	assign wr_go    = psel && penable && pwrite && !bad_addr;
	assign prdata   = prdata_ff;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_ff <= vft_pkg::CTRL_RST;
		end else if (wr_go && idx == 6'(vft_pkg::IDX_CTRL)) begin
			ctrl_ff <= pwdata[vft_pkg::CTRL_W-1:0];
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 1; i <= vft_pkg::IDX_LAST_TIM; i++) begin
				tim_ff[i] <= '0;
			end
		end else if (wr_go && idx >= 6'(vft_pkg::IDX_LINE_TOT) && idx <= 6'(vft_pkg::IDX_LAST_TIM)) begin
			tim_ff[idx] <= pwdata[CNT_W-1:0];
		end
	end

	// Read data is captured in the setup cycle so the access phase needs no wait state.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			prdata_ff <= '0;
		end else if (psel && !penable) begin
			prdata_ff <= '0;
			if (idx == 6'(vft_pkg::IDX_CTRL)) begin
				prdata_ff[vft_pkg::CTRL_W-1:0] <= ctrl_ff;
			end else if (idx >= 6'(vft_pkg::IDX_LINE_TOT) && idx <= 6'(vft_pkg::IDX_LAST_TIM)) begin
				prdata_ff[CNT_W-1:0] <= tim_ff[idx];
			end else if (idx == 6'(vft_pkg::IDX_STATUS)) begin
				prdata_ff[CNT_W-1:0] <= line_ff;
				prdata_ff[vft_pkg::STAT_PIX_LSB +: CNT_W] <= pix_ff;
				prdata_ff[vft_pkg::STAT_FIELD_BIT] <= field_ff;
			end
		end
	end

	// ==========================================================
	// Counters
	logic             en;
	logic             ilace;
	logic             line_end;
	logic             mid_tick;
	logic             vtick;
	logic [CNT_W-1:0] nxt_line;
	logic [CNT_W-1:0] half;
	logic [CNT_W-1:0] ltc;
	logic [CNT_W-1:0] vtot;

	assign en       = ctrl_ff[vft_pkg::CTRL_EN_BIT];
	assign ilace    = !ctrl_ff[vft_pkg::CTRL_NOILACE_BIT];
	assign ltc      = tim_ff[vft_pkg::IDX_LINE_TOT];
	assign vtot     = tim_ff[vft_pkg::IDX_FRAME_TOT];
	assign half     = ltc >> 1;
	assign line_end = en && (pix_ff == ltc);
	assign mid_tick = en && ilace && (pix_ff == half);
	assign vtick    = line_end || mid_tick;
	assign nxt_line = (line_ff == vtot) ? '0 : line_ff + 1'b1;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pix_ff <= '0;
		end else if (!en || line_end) begin
			pix_ff <= '0;
		end else begin
			pix_ff <= pix_ff + 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			line_ff <= '0;
		end else if (!en) begin
			line_ff <= '0;
		end else if (vtick) begin
			line_ff <= nxt_line;
		end
	end

	// An odd halfline total makes the second field start at the middle of a line.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			field_ff <= vft_pkg::VFT_FIELD_ODD;
		end else if (!en || !ilace) begin
			field_ff <= vft_pkg::VFT_FIELD_ODD;
		end else if (vtick && line_ff == vtot) begin
			field_ff <= vft_pkg::vft_field_t'(!field_ff);
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			frame_int_out <= 1'b0;
		end else begin
			frame_int_out <= vtick && nxt_line == tim_ff[vft_pkg::IDX_VINT];
		end
	end

	assign field_out = field_ff;

	// ==========================================================
	// Vertical state
	logic       vsync_ff;
	logic       vs_pend_ff;
	logic       posteq_ff;
	logic       preeq_ff;
	logic       vblank_ff;
	logic       varea_ff;
	logic       va_set_ff;
	logic       va_clr_ff;
	logic       vs_rise;
	logic [CNT_W-1:0] vs_key;

	assign vs_key  = (tim_ff[vft_pkg::IDX_VSYNC_E] - 1'b1) >> 1;
	assign vs_rise = line_end && vs_pend_ff;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			vs_pend_ff <= 1'b0;
		end else if (vtick && nxt_line == vs_key) begin
			vs_pend_ff <= 1'b1;
		end else if (vs_rise || !en) begin
			vs_pend_ff <= 1'b0;
		end
	end

	// The low vertical sync level doubles as the serration region.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			vsync_ff <= 1'b1;
		end else if (!en) begin
			vsync_ff <= 1'b1;
		end else if (vtick && line_ff == vtot) begin
			vsync_ff <= 1'b0;
		end else if (vs_rise) begin
			vsync_ff <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			posteq_ff <= 1'b0;
			preeq_ff  <= 1'b0;
		end else if (!en || !ilace) begin
			posteq_ff <= 1'b0;
			preeq_ff  <= 1'b0;
		end else begin
			if (vtick && nxt_line == tim_ff[vft_pkg::IDX_VSYNC_E]) begin
				posteq_ff <= 1'b0;
			end else if (vs_rise) begin
				posteq_ff <= 1'b1;
			end
			if (vtick && line_ff == vtot) begin
				preeq_ff <= 1'b0;
			end else if (vtick && nxt_line == tim_ff[vft_pkg::IDX_VBLANK_S]) begin
				preeq_ff <= 1'b1;
			end
		end
	end

	// Blank start wins over blank end when both compare values are equal.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			vblank_ff <= 1'b1;
		end else if (!en) begin
			vblank_ff <= 1'b1;
		end else if (vtick && nxt_line == tim_ff[vft_pkg::IDX_VBLANK_S]) begin
			vblank_ff <= 1'b0;
		end else if (vtick && nxt_line == tim_ff[vft_pkg::IDX_VBLANK_E]) begin
			vblank_ff <= 1'b1;
		end
	end

	// The vertical part of area moves only at line ends so the active region stays rectangular.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			va_set_ff <= 1'b0;
			va_clr_ff <= 1'b0;
			varea_ff  <= 1'b0;
		end else if (!en) begin
			va_set_ff <= 1'b0;
			va_clr_ff <= 1'b0;
			varea_ff  <= 1'b0;
		end else if (line_end) begin
			va_set_ff <= 1'b0;
			va_clr_ff <= 1'b0;
			if (va_clr_ff || nxt_line == tim_ff[vft_pkg::IDX_VAREA_E]) begin
				varea_ff <= 1'b0;
			end else if (va_set_ff || nxt_line == tim_ff[vft_pkg::IDX_VAREA_S]) begin
				varea_ff <= 1'b1;
			end
		end else if (mid_tick) begin
			va_set_ff <= va_set_ff || nxt_line == tim_ff[vft_pkg::IDX_VAREA_S];
			va_clr_ff <= va_clr_ff || nxt_line == tim_ff[vft_pkg::IDX_VAREA_E];
		end
	end

	// ==========================================================
	// Horizontal state
	logic             hsync_ff;
	logic             composite_sync_out_ff;
	logic             hblank_ff;
	logic             harea_ff;
	logic             serr;
	logic             equ;
	logic [CNT_W-1:0] hse;
	logic [CNT_W-1:0] rise_a;
	logic [CNT_W-1:0] rise_b;

	assign hse    = tim_ff[vft_pkg::IDX_HSYNC_E];
	assign serr   = !vsync_ff;
	assign equ    = ilace && (preeq_ff || posteq_ff);
	assign rise_a = serr ? tim_ff[vft_pkg::IDX_HSERR] : (equ ? (hse >> 1) : hse);
	// The sum is one bit wider so a long line cannot lose its carry before halving.
	assign rise_b = serr ? CNT_W'(half + tim_ff[vft_pkg::IDX_HSERR]) : CNT_W'(({1'b0, ltc} + {1'b0, hse}) >> 1);

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			hsync_ff <= 1'b1;
		end else if (!en) begin
			hsync_ff <= 1'b1;
		end else if (line_end) begin
			hsync_ff <= 1'b0;
		end else if (pix_ff == hse) begin
			hsync_ff <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			composite_sync_out_ff <= 1'b1;
		end else if (!en) begin
			composite_sync_out_ff <= 1'b1;
		end else if (line_end || (mid_tick && (serr || equ))) begin
			composite_sync_out_ff <= 1'b0;
		end else if (pix_ff == rise_a || (ilace && (serr || equ) && pix_ff == rise_b)) begin
			composite_sync_out_ff <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			hblank_ff <= 1'b1;
			harea_ff  <= 1'b0;
		end else if (!en) begin
			hblank_ff <= 1'b1;
			harea_ff  <= 1'b0;
		end else begin
			if (pix_ff == tim_ff[vft_pkg::IDX_HBLANK_S]) begin
				hblank_ff <= 1'b0;
			end else if (pix_ff == tim_ff[vft_pkg::IDX_HBLANK_E]) begin
				hblank_ff <= 1'b1;
			end
			if (pix_ff == tim_ff[vft_pkg::IDX_HAREA_E]) begin
				harea_ff <= 1'b0;
			end else if (pix_ff == tim_ff[vft_pkg::IDX_HAREA_S]) begin
				harea_ff <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Output pipeline: one rising-edge stage plus a falling-edge stage gives the fixed skew.
	vft_pkg::vft_sig_t  cur_sig;
	vft_pkg::vft_sig_t  stage_ff;
	vft_pkg::vft_sig_t  pin_sig_ff;
	vft_pkg::vft_pins_t pins_ff;

	assign cur_sig = '{hsync_n:  hsync_ff,
	                   vsync_n:  vsync_ff,
	                   composite_sync_out_n:  composite_sync_out_ff,
	                   cblank_n: hblank_ff && vblank_ff,
	                   hblank_n: hblank_ff,
	                   vblank_n: vblank_ff,
	                   area:     harea_ff && varea_ff};

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			stage_ff <= vft_pkg::SIG_IDLE;
		end else begin
			stage_ff <= cur_sig;
		end
	end

	// Pin select codes other than the two legal ones fall back to the separate-blank set.
	always_ff @(negedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pin_sig_ff <= vft_pkg::SIG_IDLE;
			pins_ff    <= vft_pkg::PINS_IDLE;
		end else begin
			pin_sig_ff <= stage_ff;
			pins_ff.hsync_n <= stage_ff.hsync_n;
			pins_ff.vsync_n <= stage_ff.vsync_n;
			pins_ff.area    <= stage_ff.area;
			if (ctrl_ff[vft_pkg::CTRL_PINSEL_LSB +: 2] == vft_pkg::VFT_PINSEL_COMPOSITE) begin
				pins_ff.sync_or_hblank_n  <= stage_ff.composite_sync_out_n;
				pins_ff.blank_or_vblank_n <= stage_ff.cblank_n;
			end else begin
				pins_ff.sync_or_hblank_n  <= stage_ff.hblank_n;
				pins_ff.blank_or_vblank_n <= stage_ff.vblank_n;
			end
		end
	end

	assign video_pins  = pins_ff;
	assign all_signals = pin_sig_ff;

	// ==========================================================
	// Checks
	a_pixel_wrap: assert property (@(posedge core_clk) disable iff (!resetn)
		line_end |=> pix_ff == '0 && !hsync_ff) else $error("pixel counter did not wrap with sync");
	a_line_step: assert property (@(posedge core_clk) disable iff (!resetn)
		en && !ilace && line_end && line_ff != vtot |=> line_ff == $past(line_ff) + 1'b1)
		else $error("line counter did not advance at line end");
	a_frame_wrap: assert property (@(posedge core_clk) disable iff (!resetn)
		vtick && line_ff == vtot |=> line_ff == '0 && !vsync_ff) else $error("frame wrap missing");
	a_vsync_end: assert property (@(posedge core_clk) disable iff (!resetn)
		en && $rose(vsync_ff) |-> $past(line_end) && $past(vs_pend_ff)) else $error("vsync rose off line end");
	a_blank_follow: assert property (@(posedge core_clk) disable iff (!resetn)
		vtick && nxt_line == tim_ff[vft_pkg::IDX_VBLANK_E] && nxt_line != tim_ff[vft_pkg::IDX_VBLANK_S]
		|=> cur_sig.vblank_n && cur_sig.cblank_n == hblank_ff) else $error("blank end missed");
	a_blank_start: assert property (@(posedge core_clk) disable iff (!resetn)
		en && vtick && nxt_line == tim_ff[vft_pkg::IDX_VBLANK_S] |=> !cur_sig.vblank_n && !cur_sig.cblank_n)
		else $error("blank start missed");
	a_area_gate: assert property (@(posedge core_clk) disable iff (!resetn)
		en && $changed(varea_ff) |-> $past(line_end)) else $error("vertical area moved mid line");
	a_composite_sync_out_plain: assert property (@(posedge core_clk) disable iff (!resetn)
		vsync_ff && !equ ##1 vsync_ff && !$past(line_end) |-> composite_sync_out_ff == hsync_ff || $past(pix_ff) != hse)
		else $error("composite sync not plain outside serration");
	a_pin_skew: assert property (@(posedge core_clk) disable iff (!resetn)
		##1 1'b1 |-> all_signals == $past(cur_sig)) else $error("pin skew wrong");
	a_frame_int: assert property (@(posedge core_clk) disable iff (!resetn)
		vtick && nxt_line == tim_ff[vft_pkg::IDX_VINT] |=> frame_int_out ##1 !frame_int_out || vtick)
		else $error("frame interrupt missing");
	a_mid_step: assert property (@(posedge core_clk) disable iff (!resetn)
		mid_tick && !line_end |=> line_ff == $past(nxt_line)) else $error("halfline step missing");

endmodule

// File: verification/vft_monitor_model.sv
// Display-side model: measures sync, blank and area timing of the frame timer per frame, per line and per sync pulse.
`timescale 1ns/10ps

module vft_monitor_model (
	input  wire logic          core_clk,
	input  wire logic          resetn,
	input  vft_pkg::vft_sig_t  sig,
	input  vft_pkg::vft_pins_t pins,
	input  wire logic [1:0]    pin_sel,
	input  wire logic          frame_int,
	input  wire logic          field,
	output int                 frames,
	output int                 m [11]
);
	// ==========================================================
	// Measurement
	// Slots 0..5 cover one vertical sync period, 6 the sync width, 7..10 the last line and pulses.
	int   c [10];
	logic p_hs;
	logic p_vs;
	logic p_cs;
	logic p_fd;
	logic cs_vs;

	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			frames = 0;
			c = '{default: 0};
			m = '{default: 0};
			{p_hs, p_vs, p_cs, p_fd, cs_vs} = 5'h1c;
		end else begin
			c[0]++;
			c[1] += int'(!sig.vblank_n);
			c[2] += int'(sig.area);
			c[3] += int'(frame_int);
			c[4] += int'(field !== p_fd);
			c[5] += int'(sig.cblank_n !== (sig.hblank_n & sig.vblank_n));
			c[5] += int'(pins !== {sig.hsync_n, sig.vsync_n, (pin_sel == 2'h2) ? sig.composite_sync_out_n : sig.hblank_n,
				(pin_sel == 2'h2) ? sig.cblank_n : sig.vblank_n, sig.area});
			c[6] += int'(!sig.vsync_n);
			c[7]++;
			c[8] += int'(!sig.hsync_n);
			c[9] += int'(!sig.composite_sync_out_n);
			if (p_hs && !sig.hsync_n) begin
				m[7] = c[7];
				c[7] = 0;
			end
			if (!p_hs && sig.hsync_n) begin
				m[8] = c[8];
				c[8] = 0;
			end
			// A pulse is classed by the vertical sync level at its start, since both fall together.
			if (p_cs && !sig.composite_sync_out_n)
				cs_vs = !sig.vsync_n;
			if (!p_cs && sig.composite_sync_out_n) begin
				m[cs_vs ? 9 : 10] = c[9];
				c[9] = 0;
			end
			if (!p_vs && sig.vsync_n) begin
				m[6] = c[6];
				c[6] = 0;
			end
			if (p_vs && !sig.vsync_n) begin
				for (int k = 0; k < 6; k++) begin
					m[k] = c[k];
					c[k] = 0;
				end
				frames++;
			end
			p_hs = sig.hsync_n;
			p_vs = sig.vsync_n;
			p_cs = sig.composite_sync_out_n;
			p_fd = field;
		end
	end
endmodule

// File: verification/vft_frame_timer_bench.sv
// Self-checking bench of the frame timer: APB programming plus noninterlaced and interlaced runs.
`timescale 1ns/10ps

module vft_frame_timer_bench;
	logic                       core_clk;
	logic                       resetn;
	logic                       psel;
	logic                       penable;
	logic                       pwrite;
	logic [vft_pkg::ADDR_W-1:0] paddr;
	logic [31:0]                pwdata;
	logic [31:0]                prdata;
	logic                       pready;
	logic                       pslverr;
	vft_pkg::vft_pins_t         video_pins;
	vft_pkg::vft_sig_t          all_signals;
	logic                       frame_int_out;
	logic                       field_out;
	logic [1:0]                 pin_sel;
	int                         frames;
	int                         m [11];
	int                         r [15];
	int                         error_cnt;
	int                         comparisons;
	logic [31:0]                seed;
	logic [31:0]                rd;
	logic                       err;

	vft_frame_timer i_vft_frame_timer (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.video_pins(video_pins), .all_signals(all_signals), .frame_int_out(frame_int_out), .field_out(field_out));

	vft_monitor_model i_vft_monitor_model (.core_clk(core_clk), .resetn(resetn), .sig(all_signals),
		.pins(video_pins), .pin_sel(pin_sel), .frame_int(frame_int_out), .field(field_out), .frames(frames), .m(m));

	// ==========================================================
	// Helpers
	function automatic int rn(input int lim);
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return int'(seed % lim);
	endfunction

	function automatic int ml(input int d, input int vt);
		return (d + vt + 1) % (vt + 1);
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("Comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic apb(input logic w, input int a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a[vft_pkg::ADDR_W-1:0];
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		for (int k = 0; k <= 50; k++) begin
			@(posedge core_clk);
			if (pready === 1'b1)
				break;
			if (k == 50) begin
				error_cnt++;
				end_of_test();
			end
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_frames(input int n);
		int t;
		t = frames + n;
		for (int k = 0; k <= 20000; k++) begin
			@(negedge core_clk);
			if (frames >= t)
				break;
			if (k == 20000) begin
				error_cnt++;
				end_of_test();
			end
		end
	endtask

	// Horizontal edges nest sync inside blank so the same set suits both scan modes.
	task automatic hfill(input int h, input int s);
		r[1] = h;
		r[2] = s;
		r[3] = h / 2 - s - 2;
		r[4] = s + 2;
		r[5] = h - 2;
		r[6] = s + 3;
		r[7] = h - 4;
	endtask

	task automatic vset(input int vt, input int ve, input int vbe, input int vsb, input int vsa, input int vea,
		input int vi);
		r[8] = vt;
		r[9] = ve;
		r[10] = vbe;
		r[11] = vsb;
		r[12] = vsa;
		r[13] = vea;
		r[14] = vi;
	endtask

	// ==========================================================
	// Programming and checking of one timing set
	task automatic run(input logic noilace, input logic [1:0] pin_mode);
		int h;
		int vt;
		logic [31:0] d;
		h = r[1];
		vt = r[8];
		apb(1'b1, 0, {28'h0, 1'b0, pin_mode, noilace});
		pin_sel <= pin_mode;
		for (int i = 1; i < 15; i++) begin
			d = seed;
			apb(1'b1, 4 * i, {d[31:12], r[i][11:0]});
			apb(1'b0, 4 * i, 32'h0);
			chk(rd, {20'h0, r[i][11:0]});
		end
		apb(1'b1, 0, {28'h0, 1'b1, pin_mode, noilace});
		wait_frames(3);
		chk(m[7], h + 1);
		chk(m[8], r[2] + 1);
		if (noilace) begin
			chk(m[10], r[2] + 1);
			chk(m[9], r[3] + 1);
			chk(m[0], (vt + 1) * (h + 1));
			chk(m[6], ((r[9] - 1) / 2 + 1) * (h + 1));
			chk(m[1], ml(r[10] - r[11], vt) * (h + 1));
			chk(m[2], ml(r[13] - r[12], vt) * (r[7] - r[6]));
			chk(m[3], 1);
			chk(m[4], 0);
			chk(m[5], 0);
		end else begin
			chk(m[0], (vt + 1) * (h + 1) / 2);
			chk(m[4], 1);
		end
		apb(1'b1, 0, {28'h0, 1'b0, pin_mode, noilace});
		repeat (4) @(negedge core_clk);
		chk(video_pins, vft_pkg::PINS_IDLE);
	endtask

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	initial begin
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = 32'h0;
		pin_sel = 2'h2;
		seed = 32'd6221;
		error_cnt = 0;
		comparisons = 0;
		repeat (10) @(posedge core_clk);
		resetn <= 1'b1;
		chk(all_signals, vft_pkg::SIG_IDLE);
		apb(1'b0, 0, 32'h0);
		chk(rd, 32'(vft_pkg::CTRL_RST));
		apb(1'b0, 60, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 80, 32'h0);
		chk(rd, 32'h0);
		chk(err, 1'b0);
		apb(1'b1, 60, 32'h5);
		chk(err, 1'b1);
		apb(1'b1, 2, 32'h5);
		chk(err, 1'b1);
		hfill(31, 3);
		vset(11, 5, 3, 10, 3, 10, 11);
		run(1'b1, 2'h2);
		for (int n = 0; n < 3; n++) begin
			hfill(23 + 2 * rn(5), 3 + 2 * rn(3));
			r[8] = 9 + rn(6);
			vset(r[8], 2 * rn(r[8] - 2) + 1, 0, rn(r[8] + 1), 0, rn(r[8] + 1), rn(r[8] + 1));
			r[10] = (r[11] + 1 + rn(r[8])) % (r[8] + 1);
			r[12] = (r[13] + 1 + rn(r[8])) % (r[8] + 1);
			// Code zero is not a legal pin set; it must fall back to the separate-blank set.
			run(1'b1, (n == 1) ? 2'h0 : 2'h3);
		end
		hfill(31, 3);
		vset(20, 11, 13, 18, 14, 17, 5);
		run(1'b0, 2'h2);
		end_of_test();
	end
endmodule
